// ===== src/dbp_dev.sv
`timescale 1ns/1ps
`include "dbp_regs.svh"
module dbp_dev (
  input wire logic mclk,
  input wire logic resetn,
  dbp_bus_if.dev bus,
  output logic rd_req,
  output logic wr_req,
  output logic req_chan,
  output logic [2:0] req_addr,
  output logic [7:0] wr_data,
  input wire logic [7:0] rd_data,
  input wire logic [1:0] core_irq,
  input wire logic [1:0] out2_en,
  input wire logic [1:0] tx_ready,
  input wire logic [1:0] rx_ready
);

  dbp_pkg::dbp_dev_s r;
  dbp_pkg::dbp_dev_s n;

  // ==========================================================
  // next state
  logic rd_fall;
  logic rd_rise;
  logic wr_fall;
  logic wr_rise;
  logic one_sel;
  logic sel_chan;

  always_comb begin
    n = r;
    // pins are asynchronous to mclk: two flops before any use
    n.rd_s1 = bus.read_strobe_n;
    n.rd_s2 = r.rd_s1;
    n.rd_s3 = r.rd_s2;
    n.wr_s1 = bus.write_strobe_n;
    n.wr_s2 = r.wr_s1;
    n.wr_s3 = r.wr_s2;
    n.sel_s1 = {bus.chan_b_select_n, bus.chan_a_select_n};
    n.sel_s2 = r.sel_s1;
    n.addr_s1 = bus.reg_addr;
    n.addr_s2 = r.addr_s1;
    n.dat_s1 = bus.data_bus;
    n.dat_s2 = r.dat_s1;

    rd_fall = r.rd_s3 & ~r.rd_s2;
    rd_rise = ~r.rd_s3 & r.rd_s2;
    wr_fall = r.wr_s3 & ~r.wr_s2;
    wr_rise = ~r.wr_s3 & r.wr_s2;
    // exactly one select low; both low is ignored as a host fault
    one_sel = ^r.sel_s2;
    sel_chan = r.sel_s2[0] ? `DBP_CHAN_B : `DBP_CHAN_A;

    n.rd_req = 1'h0;
    n.wr_req = 1'h0;

    // ==========================================================
    // read cycle
    if (rd_fall && one_sel && !r.wr_busy) begin
      n.rd_busy = 1'h1;
      n.acc_chan = sel_chan;
      n.acc_addr = r.addr_s2;
      n.rd_req = 1'h1;
      n.req_chan = sel_chan;
      n.req_addr = r.addr_s2;
    end
    // the core answers in the same cycle as the request
    if (r.rd_req && r.rd_busy) begin
      n.dout = rd_data;
      n.dout_oe_n = 1'h0;
    end
    // drive stops at the strobe rise or when the select goes away,
    // so the bus is freed three cycles after the host raises the strobe
    if (r.rd_busy && (rd_rise || r.sel_s2[r.acc_chan])) begin
      n.rd_busy = 1'h0;
      n.dout_oe_n = 1'h1;
    end

    // ==========================================================
    // write cycle
    if (wr_fall && one_sel && !r.rd_busy) begin
      n.wr_busy = 1'h1;
      n.acc_chan = sel_chan;
      n.acc_addr = r.addr_s2;
    end
    // the rise is checked first: host releases select after it
    if (r.wr_busy && wr_rise) begin
      n.wr_busy = 1'h0;
      n.wr_req = 1'h1;
      n.req_chan = r.acc_chan;
      n.req_addr = r.acc_addr;
      n.wr_data = r.dat_s2;
    end else if (r.wr_busy && r.sel_s2[r.acc_chan]) begin
      n.wr_busy = 1'h0;
    end

    // ==========================================================
    // per-channel status pins
    for (int i = 0; i < 2; i++) begin
      n.irq[i] = core_irq[i];
      n.irq_oe_n[i] = ~out2_en[i];
      n.aux2_n[i] = ~out2_en[i];
      n.txr_n[i] = ~tx_ready[i];
      n.rxr_n[i] = ~rx_ready[i];
    end
  end

  // ==========================================================
  // state register
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      r <= '0;
      r.rd_s1 <= 1'h1;
      r.rd_s2 <= 1'h1;
      r.rd_s3 <= 1'h1;
      r.wr_s1 <= 1'h1;
      r.wr_s2 <= 1'h1;
      r.wr_s3 <= 1'h1;
      r.sel_s1 <= 2'h3;
      r.sel_s2 <= 2'h3;
      r.dat_s1 <= `DBP_BUS_IDLE;
      r.dat_s2 <= `DBP_BUS_IDLE;
      r.dout_oe_n <= 1'h1;
      // interrupt released and aux high until the control bit is set
      r.irq_oe_n <= {2{~`DBP_OUT2_RST}};
      r.aux2_n <= {2{~`DBP_OUT2_RST}};
      r.txr_n <= 2'h3;
      r.rxr_n <= 2'h3;
    end else begin
      r <= n;
    end
  end

  // ==========================================================
  // outputs, all straight from the state register
  assign rd_req = r.rd_req;
  assign wr_req = r.wr_req;
  assign req_chan = r.req_chan;
  assign req_addr = r.req_addr;
  assign wr_data = r.wr_data;

  assign bus.dev_data_out = r.dout;
  assign bus.dev_data_oe_n = r.dout_oe_n;
  assign bus.chan_a_irq_drv = r.irq[0];
  assign bus.chan_b_irq_drv = r.irq[1];
  assign bus.chan_a_irq_oe_n = r.irq_oe_n[0];
  assign bus.chan_b_irq_oe_n = r.irq_oe_n[1];
  assign bus.chan_a_aux_out2_n = r.aux2_n[0];
  assign bus.chan_b_aux_out2_n = r.aux2_n[1];
  assign bus.chan_a_tx_ready_n = r.txr_n[0];
  assign bus.chan_b_tx_ready_n = r.txr_n[1];
  assign bus.chan_a_rx_ready_n = r.rxr_n[0];
  assign bus.chan_b_rx_ready_n = r.rxr_n[1];

endmodule : dbp_dev

// ===== src/dbp_regs.svh
`ifndef DBP_REGS_SVH
`define DBP_REGS_SVH
// Summary of operation
// - three address bits pick one channel register
// - eight-bit data bus, device drives only reads
// - read strobe fall starts fetch of addressed byte
// - device drives byte, host captures at strobe rise
// - write strobe rise loads host byte into register
// - channel A answers only while its select low
// - channel B answers only while its select low
// - control bit set: drive interrupt, aux two low
// - control bit clear: interrupt released, aux high
// - active-low transmit ready reflects transmit holding state
// - active-low receive ready reflects receive holding state
// - aux output two is not general purpose

// ==========================================================
// channel numbering and control bit position
`define DBP_CHAN_A 1'h0
`define DBP_CHAN_B 1'h1
`define DBP_OUT2_BIT 3
`define DBP_OUT2_RST 1'h0
`define DBP_BUS_IDLE 8'hff

// ==========================================================
// host strobe timing, least times rounded up to cycles
`define DBP_CLK_NS 50
`define DBP_SETUP_NS 100
`define DBP_STROBE_NS 400
`define DBP_HOLD_NS 100
`define DBP_SETUP_CYC ((`DBP_SETUP_NS + `DBP_CLK_NS - 1) / `DBP_CLK_NS)
`define DBP_STROBE_CYC ((`DBP_STROBE_NS + `DBP_CLK_NS - 1) / `DBP_CLK_NS)
`define DBP_HOLD_CYC ((`DBP_HOLD_NS + `DBP_CLK_NS - 1) / `DBP_CLK_NS)
`endif

// ===== src/dbp_pkg.sv
package dbp_pkg;

  typedef enum logic [1:0] {
    DBP_H_IDLE = 2'h0,
    DBP_H_SETUP = 2'h1,
    DBP_H_STROBE = 2'h3,
    DBP_H_HOLD = 2'h2
  } dbp_host_state_e;

  typedef struct packed {
    logic rd_s1;
    logic rd_s2;
    logic rd_s3;
    logic wr_s1;
    logic wr_s2;
    logic wr_s3;
    logic [1:0] sel_s1;
    logic [1:0] sel_s2;
    logic [2:0] addr_s1;
    logic [2:0] addr_s2;
    logic [7:0] dat_s1;
    logic [7:0] dat_s2;
    logic rd_busy;
    logic wr_busy;
    logic acc_chan;
    logic [2:0] acc_addr;
    logic [7:0] dout;
    logic dout_oe_n;
    logic rd_req;
    logic wr_req;
    logic req_chan;
    logic [2:0] req_addr;
    logic [7:0] wr_data;
    logic [1:0] irq;
    logic [1:0] irq_oe_n;
    logic [1:0] aux2_n;
    logic [1:0] txr_n;
    logic [1:0] rxr_n;
  } dbp_dev_s;

  typedef struct packed {
    dbp_host_state_e state;
    logic [7:0] cnt;
    logic is_wr;
    logic [2:0] addr;
    logic [7:0] wdata;
    logic [1:0] sel_n;
    logic rd_n;
    logic wr_n;
    logic doe_n;
    logic cmd_ready;
    logic rsp_valid;
    logic [7:0] rsp_data;
    logic [7:0] dat_s1;
    logic [7:0] dat_s2;
    logic [1:0] irq_s1;
    logic [1:0] irq_s2;
    logic [1:0] txr_s1;
    logic [1:0] txr_s2;
    logic [1:0] rxr_s1;
    logic [1:0] rxr_s2;
  } dbp_host_s;

endpackage : dbp_pkg

// ===== src/dbp_bus_if.sv
`timescale 1ns/1ps
`include "dbp_regs.svh"
interface dbp_bus_if;
  logic [2:0] reg_addr;
  logic [7:0] host_data_out;
  logic host_data_oe_n;
  logic [7:0] dev_data_out;
  logic dev_data_oe_n;
  logic [7:0] data_bus;
  logic read_strobe_n;
  logic write_strobe_n;
  logic chan_a_select_n;
  logic chan_b_select_n;
  logic chan_a_irq_drv;
  logic chan_a_irq_oe_n;
  logic chan_a_irq;
  logic chan_b_irq_drv;
  logic chan_b_irq_oe_n;
  logic chan_b_irq;
  logic chan_a_aux_out2_n;
  logic chan_b_aux_out2_n;
  logic chan_a_tx_ready_n;
  logic chan_b_tx_ready_n;
  logic chan_a_rx_ready_n;
  logic chan_b_rx_ready_n;

  // pull-up on the data bus, pull-down on released interrupt pins
  assign data_bus = !dev_data_oe_n ? dev_data_out :
                    (!host_data_oe_n ? host_data_out : `DBP_BUS_IDLE);
  assign chan_a_irq = !chan_a_irq_oe_n ? chan_a_irq_drv : 1'h0;
  assign chan_b_irq = !chan_b_irq_oe_n ? chan_b_irq_drv : 1'h0;

  modport dev (
    input reg_addr, data_bus, read_strobe_n, write_strobe_n,
    input chan_a_select_n, chan_b_select_n,
    output dev_data_out, dev_data_oe_n,
    output chan_a_irq_drv, chan_a_irq_oe_n, chan_b_irq_drv, chan_b_irq_oe_n,
    output chan_a_aux_out2_n, chan_b_aux_out2_n,
    output chan_a_tx_ready_n, chan_b_tx_ready_n,
    output chan_a_rx_ready_n, chan_b_rx_ready_n
  );

  modport host (
    output reg_addr, host_data_out, host_data_oe_n,
    output read_strobe_n, write_strobe_n, chan_a_select_n, chan_b_select_n,
    input data_bus, chan_a_irq, chan_b_irq,
    input chan_a_tx_ready_n, chan_b_tx_ready_n,
    input chan_a_rx_ready_n, chan_b_rx_ready_n
  );
endinterface : dbp_bus_if

// ===== src/dbp_host.sv
`timescale 1ns/1ps
`include "dbp_regs.svh"
module dbp_host #(
  parameter int SETUP_CYC = `DBP_SETUP_CYC,
  parameter int STROBE_CYC = `DBP_STROBE_CYC,
  parameter int HOLD_CYC = `DBP_HOLD_CYC
) (
  input wire logic mclk,
  input wire logic resetn,
  dbp_bus_if.host bus,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic cmd_write,
  input wire logic cmd_chan,
  input wire logic [2:0] cmd_addr,
  input wire logic [7:0] cmd_wdata,
  output logic rsp_valid,
  output logic [7:0] rsp_data,
  output logic [1:0] irq_level,
  output logic [1:0] tx_ready_n,
  output logic [1:0] rx_ready_n
);

  dbp_pkg::dbp_host_s r;
  dbp_pkg::dbp_host_s n;

  // ==========================================================
  // next state
  always_comb begin
    n = r;
    n.dat_s1 = bus.data_bus;
    n.dat_s2 = r.dat_s1;
    n.irq_s1 = {bus.chan_b_irq, bus.chan_a_irq};
    n.irq_s2 = r.irq_s1;
    n.txr_s1 = {bus.chan_b_tx_ready_n, bus.chan_a_tx_ready_n};
    n.txr_s2 = r.txr_s1;
    n.rxr_s1 = {bus.chan_b_rx_ready_n, bus.chan_a_rx_ready_n};
    n.rxr_s2 = r.rxr_s1;
    n.rsp_valid = 1'h0;
    n.cnt = r.cnt + 8'h01;

    unique case (r.state)
      dbp_pkg::DBP_H_IDLE: begin
        n.cnt = 8'h00;
        if (cmd_valid && r.cmd_ready) begin
          n.cmd_ready = 1'h0;
          n.is_wr = cmd_write;
          n.addr = cmd_addr;
          n.wdata = cmd_wdata;
          // only one select at a time, set before the strobe
          n.sel_n = (cmd_chan == `DBP_CHAN_B) ? 2'h1 : 2'h2;
          n.doe_n = ~cmd_write;
          n.state = dbp_pkg::DBP_H_SETUP;
        end
      end
      dbp_pkg::DBP_H_SETUP: begin
        if (r.cnt == 8'(SETUP_CYC - 1)) begin
          n.cnt = 8'h00;
          n.rd_n = r.is_wr;
          n.wr_n = ~r.is_wr;
          n.state = dbp_pkg::DBP_H_STROBE;
        end
      end
      dbp_pkg::DBP_H_STROBE: begin
        if (r.cnt == 8'(STROBE_CYC - 1)) begin
          n.cnt = 8'h00;
          n.rd_n = 1'h1;
          n.wr_n = 1'h1;
          if (!r.is_wr) begin
            // synchronised copy reflects the bus while still driven
            n.rsp_data = r.dat_s2;
            n.rsp_valid = 1'h1;
          end
          n.state = dbp_pkg::DBP_H_HOLD;
        end
      end
      dbp_pkg::DBP_H_HOLD: begin
        // address, select and data held past the rise
        if (r.cnt == 8'(HOLD_CYC - 1)) begin
          n.cnt = 8'h00;
          n.sel_n = 2'h3;
          n.doe_n = 1'h1;
          n.cmd_ready = 1'h1;
          n.state = dbp_pkg::DBP_H_IDLE;
        end
      end
    endcase
  end

  // ==========================================================
  // state register
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      r <= '0;
      r.state <= dbp_pkg::DBP_H_IDLE;
      r.sel_n <= 2'h3;
      r.rd_n <= 1'h1;
      r.wr_n <= 1'h1;
      r.doe_n <= 1'h1;
      r.cmd_ready <= 1'h1;
      r.txr_s1 <= 2'h3;
      r.txr_s2 <= 2'h3;
      r.rxr_s1 <= 2'h3;
      r.rxr_s2 <= 2'h3;
    end else begin
      r <= n;
    end
  end

  // ==========================================================
  // outputs
  assign bus.reg_addr = r.addr;
  assign bus.host_data_out = r.wdata;
  assign bus.host_data_oe_n = r.doe_n;
  assign bus.read_strobe_n = r.rd_n;
  assign bus.write_strobe_n = r.wr_n;
  assign bus.chan_a_select_n = r.sel_n[0];
  assign bus.chan_b_select_n = r.sel_n[1];
  assign cmd_ready = r.cmd_ready;
  assign rsp_valid = r.rsp_valid;
  assign rsp_data = r.rsp_data;
  assign irq_level = r.irq_s2;
  assign tx_ready_n = r.txr_s2;
  assign rx_ready_n = r.rxr_s2;

endmodule : dbp_host

// ===== tb/dbp_bus_properties.sv
`timescale 1ns/1ps
// ==========================================================
// bus checks, both ends are design code
module dbp_bus_properties (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic [2:0] reg_addr,
  input wire logic dev_data_oe_n,
  input wire logic host_data_oe_n,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic chan_a_select_n,
  input wire logic chan_b_select_n,
  input wire logic chan_a_irq_oe_n,
  input wire logic chan_b_irq_oe_n,
  input wire logic chan_a_aux_out2_n,
  input wire logic chan_b_aux_out2_n
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);

  // a read counts only with exactly one channel selected
  sequence dbp_rd_start;
    $fell(read_strobe_n) ##0 (chan_a_select_n != chan_b_select_n);
  endsequence
  sequence dbp_rd_hold;
    !read_strobe_n ##1 !read_strobe_n;
  endsequence

  // ==========================================================
  // device side
  AST_RD_DRIVE: assert property (
    dbp_rd_start |-> ##[3:6] !dev_data_oe_n)
    else $error("read data never driven");
  AST_RD_RELEASE: assert property (
    $rose(read_strobe_n) |-> ##[1:4] dev_data_oe_n)
    else $error("read data not released");
  AST_IDLE_QUIET: assert property (
    read_strobe_n [*5] |-> dev_data_oe_n)
    else $error("data driven outside a read");
  AST_NO_FIGHT: assert property (
    !dev_data_oe_n |-> host_data_oe_n)
    else $error("both ends drive the data bus");
  AST_WR_QUIET: assert property (
    !write_strobe_n [*3] |-> dev_data_oe_n)
    else $error("device drives during a write");
  AST_NO_SEL: assert property (
    (chan_a_select_n && chan_b_select_n) [*5] |-> dev_data_oe_n)
    else $error("device answers while unselected");
  AST_IRQ_A: assert property (
    chan_a_irq_oe_n == chan_a_aux_out2_n)
    else $error("channel a irq enable and aux disagree");
  AST_IRQ_B: assert property (
    chan_b_irq_oe_n == chan_b_aux_out2_n)
    else $error("channel b irq enable and aux disagree");
  AST_RST_DEFAULT: assert property (
    $rose(resetn) |-> chan_a_aux_out2_n && chan_b_aux_out2_n)
    else $error("aux output low after reset");

  // ==========================================================
  // host side
  AST_ONE_SEL: assert property (
    chan_a_select_n || chan_b_select_n)
    else $error("two selects low");
  AST_RD_LONG: assert property (
    dbp_rd_start |-> !read_strobe_n [*5])
    else $error("read strobe too short");
  AST_ADDR_HELD: assert property (
    dbp_rd_hold |-> $stable(reg_addr))
    else $error("address moved during read");
endmodule : dbp_bus_properties

// ===== tb/tb.sv
`timescale 1ns/1ps
module tb;
  logic mclk, resetn, cmd_valid, cmd_ready, cmd_write, cmd_chan;
  logic rd_req, wr_req, req_chan, rsp_valid;
  logic [2:0] cmd_addr, req_addr;
  logic [7:0] cmd_wdata, rsp_data, wr_data, rd_data;
  logic [1:0] core_irq, out2_en, tx_ready, rx_ready;
  logic [1:0] irq_level, tx_ready_n, rx_ready_n;
  logic [7:0] mem [2][8];
  logic [7:0] shadow [2][8];
  int bad_count, n_tests;

  dbp_bus_if bus ();
  dbp_dev dbp_dev_i (.mclk(mclk), .resetn(resetn), .bus(bus),
    .rd_req(rd_req), .wr_req(wr_req), .req_chan(req_chan),
    .req_addr(req_addr), .wr_data(wr_data), .rd_data(rd_data),
    .core_irq(core_irq), .out2_en(out2_en), .tx_ready(tx_ready),
    .rx_ready(rx_ready));
  dbp_host dbp_host_i (.mclk(mclk), .resetn(resetn), .bus(bus),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_write(cmd_write),
    .cmd_chan(cmd_chan), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .irq_level(irq_level),
    .tx_ready_n(tx_ready_n), .rx_ready_n(rx_ready_n));
  dbp_bus_properties dbp_bus_properties_i (.mclk(mclk), .resetn(resetn),
    .reg_addr(bus.reg_addr), .dev_data_oe_n(bus.dev_data_oe_n),
    .host_data_oe_n(bus.host_data_oe_n),
    .read_strobe_n(bus.read_strobe_n), .write_strobe_n(bus.write_strobe_n),
    .chan_a_select_n(bus.chan_a_select_n),
    .chan_b_select_n(bus.chan_b_select_n),
    .chan_a_irq_oe_n(bus.chan_a_irq_oe_n),
    .chan_b_irq_oe_n(bus.chan_b_irq_oe_n),
    .chan_a_aux_out2_n(bus.chan_a_aux_out2_n),
    .chan_b_aux_out2_n(bus.chan_b_aux_out2_n));

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  // ==========================================================
  // channel core stand-in: register file behind the device
  always @(negedge mclk) begin
    if (rd_req === 1'b1) rd_data <= mem[req_chan][req_addr];
    if (wr_req === 1'b1) mem[req_chan][req_addr] <= wr_data;
  end

  function automatic logic exp_irq(logic en, logic src);
    return en ? src : 1'b0; // released pin is pulled down
  endfunction : exp_irq

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic close_out();
    if (bad_count == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : close_out

  task automatic wait_for(ref logic sig);
    int n;
    n = 0;
    while (sig !== 1'b1 && n < 100) begin
      @(negedge mclk);
      n++;
    end
    if (n >= 100) begin
      bad_count++;
      $display("[ERR] %0t no handshake", $time);
    end
  endtask : wait_for

  task automatic do_cmd(logic w, logic ch, logic [2:0] a, logic [7:0] d);
    wait_for(cmd_ready);
    cmd_valid = 1'b1;
    cmd_write = w;
    cmd_chan = ch;
    cmd_addr = a;
    cmd_wdata = d;
    @(negedge mclk);
    cmd_valid = 1'b0;
    if (w) shadow[ch][a] = d;
    else begin
      wait_for(rsp_valid);
      check(rsp_data, shadow[ch][a]);
    end
  endtask : do_cmd

  initial begin
    #200_000;
    bad_count++;
    close_out();
  end

  // ==========================================================
  // main sequence
  initial begin
    void'($urandom(90));
    {resetn, cmd_valid, cmd_write, cmd_chan, cmd_addr, cmd_wdata} = '0;
    {core_irq, out2_en, tx_ready, rx_ready} = '0;
    bad_count = 0;
    n_tests = 0;
    for (int c = 0; c < 2; c++) begin
      for (int a = 0; a < 8; a++) begin
        mem[c][a] = 8'($urandom);
        shadow[c][a] = mem[c][a];
      end
    end
    repeat (4) @(negedge mclk);
    resetn = 1'b1;
    @(negedge mclk);
    check({6'h0, bus.chan_b_aux_out2_n, bus.chan_a_aux_out2_n}, 8'h03);
    // same address on both channels must not alias
    do_cmd(1'b1, 1'b0, 3'h7, 8'ha5);
    do_cmd(1'b1, 1'b1, 3'h7, 8'h5a);
    do_cmd(1'b0, 1'b0, 3'h7, 8'h00);
    do_cmd(1'b0, 1'b1, 3'h7, 8'h00);
    do_cmd(1'b1, 1'b1, 3'h0, 8'h00);
    do_cmd(1'b0, 1'b1, 3'h0, 8'h00);
    repeat (24) do_cmd(1'($urandom), 1'($urandom), 3'($urandom),
      8'($urandom));
    repeat (10) begin
      {core_irq, out2_en, tx_ready, rx_ready} = 8'($urandom);
      do_cmd(1'b0, 1'($urandom), 3'($urandom), 8'h00);
      repeat (5) @(negedge mclk);
      check({6'h0, irq_level}, {6'h0,
        exp_irq(out2_en[1], core_irq[1]), exp_irq(out2_en[0], core_irq[0])});
      check({6'h0, tx_ready_n}, {6'h0, ~tx_ready});
      check({6'h0, rx_ready_n}, {6'h0, ~rx_ready});
      // aux follows only the enable bit, never a free output
      check({6'h0, bus.chan_b_aux_out2_n,
        bus.chan_a_aux_out2_n}, {6'h0, ~out2_en});
    end
    close_out();
  end
endmodule : tb
